/* File: hw/rss_pkg.sv */
// Function
// - Hold reset 1024 oscillator cycles after delay
// - Settle count only crystal modes, powerup or wake
// - Two-bit field picks one of four trip levels
// - Enable bit clear disables brown-out, set enables
// - Brown-out only after dip exceeds filter time
// - Stay in brown-out, then full powerup delay
// - Dip during delay restarts the full delay
// - Brown-out enabled forces powerup timer on
// - Irq wake with global enable loads vector
// - Power-on status shows timeout and powerdown set
// - Unimplemented register bits always read zero
// - Powerup timer holds chip reset, RC clocked
package rss_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 5;
  localparam int unsigned OSC_SETTLE_CYCLES   = 1024;
  localparam int unsigned BOR_FILTER_TIME_NS  = 100;
  localparam int unsigned BOR_FILTER_CYCLES   =
    (BOR_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_DELAY_TICKS   = 72;
  localparam int unsigned RC_TICK_DIV         = 200;

  // ---------------------------------------------------------------
  // Oscillator mode encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] OSC_LOW_POWER_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_STANDARD_CRYSTAL  = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED_CRYSTAL = 2'h2;
  localparam logic [1:0] OSC_RC_MODE           = 2'h3;

  // ---------------------------------------------------------------
  // Register reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PC_LOW_RESET       = 8'h00;
  localparam logic [7:0] ALL_ONES_RESET     = 8'hFF;
  localparam logic [7:0] STATUS_POR_VALUE   = 8'h18;
  localparam logic [7:0] STATUS_POR_MASK    = 8'hF8;
  localparam logic [7:0] IRQ_VECTOR_LOW     = 8'h04;

  // Reset cause as seen by the core
  typedef enum logic [2:0] {
    RSS_CAUSE_NONE  = 3'b000,
    RSS_CAUSE_POR   = 3'b001,
    RSS_CAUSE_BOR   = 3'b010,
    RSS_CAUSE_MASTER_CLEAR_PIN  = 3'b011,
    RSS_CAUSE_WDT   = 3'b100,
    RSS_CAUSE_WAKE  = 3'b101
  } rss_cause_t;

  // Register load commands toward the core
  typedef struct packed {
    logic       load;
    logic [7:0] pc_low;
    logic       keep_pc;
    logic [7:0] status;
    logic       status_load;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] option_value;
    logic       dir_load;
    logic [7:0] timer_period_register;
  } rss_regload_t;

endpackage

/* File: hw/rss_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous level inputs
module rss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second
  always_comb
  begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

/* File: hw/rss_top.sv */
`timescale 1ns/1ps
// Reset and start-up sequencer
module rss_top
  import rss_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Analogue and pin inputs (asynchronous)
  input  wire logic         supply_above_trip,
  input  wire logic         osc_input_pin,
  input  wire logic         master_clear_pin_n,
  input  wire logic         power_on_pulse,
  // Core side events
  input  wire logic         watchdog_timeout,
  input  wire logic         wake_event,
  input  wire logic         wake_by_irq,
  input  wire logic         global_irq_enable,
  // Configuration
  input  wire logic [1:0]   brownout_level_select,
  input  wire logic         brownout_detect_enable,
  input  wire logic         powerup_timer_enable_n,
  input  wire logic [1:0]   osc_mode,
  // Outputs
  output logic [1:0]        trip_level_sel,
  output logic              brownout_reset,
  output logic              chip_reset,
  output logic              osc_settle_busy,
  output logic              pwrup_busy,
  output rss_cause_t        reset_cause,
  output rss_regload_t      reg_load
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] async_in;
  logic [3:0] sync_in;
  logic       sup_ok;
  logic       osc_s;
  logic       master_clear_pin_n_s;
  logic       por_s;

  assign async_in = {power_on_pulse, master_clear_pin_n, osc_input_pin, supply_above_trip};

  rss_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .d        (async_in),
    .q        (sync_in)
  );

  assign sup_ok   = sync_in[0];
  assign osc_s    = sync_in[1];
  assign master_clear_pin_n_s = sync_in[2];
  assign por_s    = sync_in[3];

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  logic [15:0]  filt_cnt_r,  filt_cnt_nxt;
  logic         bor_r,       bor_nxt;
  logic [7:0]   rc_div_r,    rc_div_nxt;
  logic [7:0]   powerup_delay_timer_cnt_r,  powerup_delay_timer_cnt_nxt;
  logic         powerup_delay_timer_r,      powerup_delay_timer_nxt;
  logic [10:0]  ost_cnt_r,   ost_cnt_nxt;
  logic         ost_r,       ost_nxt;
  logic         osc_d_r,     osc_d_nxt;
  logic         chip_rst_r,  chip_rst_nxt;
  logic         src_any_d_r, src_any_d_nxt;
  logic [1:0]   lvl_r,       lvl_nxt;
  rss_cause_t   cause_r,     cause_nxt;
  rss_regload_t load_r,      load_nxt;

  logic bor_en;
  logic rc_tick;
  logic osc_rise;
  logic crystal;
  logic src_any;
  logic powerup_delay_timer_start;
  logic ost_start;
  logic powerup_delay_timer_done;

  assign bor_en   = brownout_detect_enable;
  assign rc_tick  = (rc_div_r == 8'(RC_TICK_DIV - 1));
  assign osc_rise = osc_s && !osc_d_r;
  assign crystal  = (osc_mode != OSC_RC_MODE);
  // Brown-out forces the timer, else the enable bit decides
  assign powerup_delay_timer_start = (por_s && (!powerup_timer_enable_n || bor_en))
                    || (bor_r && bor_en && sup_ok);
  assign powerup_delay_timer_done  = powerup_delay_timer_r && rc_tick && (powerup_delay_timer_cnt_r == 8'(PWRUP_DELAY_TICKS - 1));
  assign ost_start  = crystal && (powerup_delay_timer_done || (por_s && !powerup_delay_timer_start && !powerup_delay_timer_r)
                    || wake_event);
  assign src_any    = bor_r || !master_clear_pin_n_s || watchdog_timeout || por_s
                    || powerup_delay_timer_r || ost_r;

  // ---------------------------------------------------------------
  // Brown-out filter and timers
  // ---------------------------------------------------------------
  always_comb
  begin
    lvl_nxt      = brownout_level_select;
    filt_cnt_nxt = filt_cnt_r;
    bor_nxt      = bor_r;
    if (!bor_en)
    begin
      filt_cnt_nxt = 16'h0000;
      bor_nxt      = 1'b0;
    end
    else if (sup_ok)
    begin
      filt_cnt_nxt = 16'h0000;
      bor_nxt      = 1'b0;
    end
    else if (bor_r)
      bor_nxt = 1'b1;
    else if (filt_cnt_r == 16'(BOR_FILTER_CYCLES - 1))
      bor_nxt = 1'b1;
    else
      filt_cnt_nxt = filt_cnt_r + 16'h0001;

    // Divider approximating the internal RC clock
    rc_div_nxt = rc_tick ? 8'h00 : rc_div_r + 8'h01;

    powerup_delay_timer_nxt     = powerup_delay_timer_r;
    powerup_delay_timer_cnt_nxt = powerup_delay_timer_cnt_r;
    // Only a live brown-out clears the timer; the exit cycle must reach the start branch
    if (bor_nxt)
    begin
      powerup_delay_timer_nxt     = 1'b0;
      powerup_delay_timer_cnt_nxt = 8'h00;
    end
    else if (powerup_delay_timer_start)
    begin
      powerup_delay_timer_nxt     = 1'b1;
      powerup_delay_timer_cnt_nxt = 8'h00;
    end
    else if (powerup_delay_timer_done)
      powerup_delay_timer_nxt = 1'b0;
    else if (powerup_delay_timer_r && rc_tick)
      powerup_delay_timer_cnt_nxt = powerup_delay_timer_cnt_r + 8'h01;

    osc_d_nxt   = osc_s;
    ost_nxt     = ost_r;
    ost_cnt_nxt = ost_cnt_r;
    if (bor_r || powerup_delay_timer_r && !powerup_delay_timer_done)
      ost_nxt = 1'b0;
    else if (ost_start && !ost_r)
    begin
      ost_nxt     = 1'b1;
      ost_cnt_nxt = 11'h000;
    end
    else if (ost_r && osc_rise)
    begin
      if (ost_cnt_r == 11'(OSC_SETTLE_CYCLES - 1))
        ost_nxt = 1'b0;
      else
        ost_cnt_nxt = ost_cnt_r + 11'h001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      filt_cnt_r <= 16'h0000;
      bor_r      <= 1'b0;
      rc_div_r   <= 8'h00;
      powerup_delay_timer_cnt_r <= 8'h00;
      powerup_delay_timer_r     <= 1'b0;
      ost_cnt_r  <= 11'h000;
      ost_r      <= 1'b0;
      osc_d_r    <= 1'b0;
      lvl_r      <= 2'h0;
    end
    else
    begin
      filt_cnt_r <= filt_cnt_nxt;
      bor_r      <= bor_nxt;
      rc_div_r   <= rc_div_nxt;
      powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_nxt;
      powerup_delay_timer_r     <= powerup_delay_timer_nxt;
      ost_cnt_r  <= ost_cnt_nxt;
      ost_r      <= ost_nxt;
      osc_d_r    <= osc_d_nxt;
      lvl_r      <= lvl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Final reset, cause and register load values
  // ---------------------------------------------------------------
  always_comb
  begin
    chip_rst_nxt  = src_any;
    src_any_d_nxt = src_any;
    cause_nxt     = cause_r;
    if (por_s)
      cause_nxt = RSS_CAUSE_POR;
    else if (bor_r)
      cause_nxt = RSS_CAUSE_BOR;
    else if (!master_clear_pin_n_s)
      cause_nxt = RSS_CAUSE_MASTER_CLEAR_PIN;
    else if (watchdog_timeout)
      cause_nxt = RSS_CAUSE_WDT;
    else if (wake_event)
      cause_nxt = RSS_CAUSE_WAKE;

    load_nxt                       = load_r;
    load_nxt.load                  = 1'b0;
    // One load pulse when the reset drops or on wake
    if ((src_any_d_r && !src_any) || (wake_event && !src_any))
    begin
      load_nxt.load                  = 1'b1;
      load_nxt.timer_period_register = ALL_ONES_RESET;
      load_nxt.keep_pc               = 1'b0;
      load_nxt.pc_low                = PC_LOW_RESET;
      load_nxt.status_load           = 1'b0;
      load_nxt.dir_load              = 1'b1;
      // Unknown flag bits driven as zero; unimplemented reads zero
      load_nxt.status                = STATUS_POR_VALUE & STATUS_POR_MASK;
      load_nxt.port_a_direction      = ALL_ONES_RESET;
      load_nxt.port_b_direction      = ALL_ONES_RESET;
      load_nxt.option_value          = ALL_ONES_RESET;
      if (cause_r == RSS_CAUSE_POR || cause_r == RSS_CAUSE_BOR)
        load_nxt.status_load = 1'b1;
      if (wake_event && !src_any)
      begin
        load_nxt.dir_load = 1'b0;
        load_nxt.keep_pc  = !(wake_by_irq && global_irq_enable);
        if (wake_by_irq && global_irq_enable)
          load_nxt.pc_low = IRQ_VECTOR_LOW;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      chip_rst_r  <= 1'b1;
      src_any_d_r <= 1'b1;
      cause_r     <= RSS_CAUSE_NONE;
      load_r      <= '0;
    end
    else
    begin
      chip_rst_r  <= chip_rst_nxt;
      src_any_d_r <= src_any_d_nxt;
      cause_r     <= cause_nxt;
      load_r      <= load_nxt;
    end
  end

  assign trip_level_sel  = lvl_r;
  assign brownout_reset  = bor_r;
  assign chip_reset      = chip_rst_r;
  assign osc_settle_busy = ost_r;
  assign pwrup_busy      = powerup_delay_timer_r;
  assign reset_cause     = cause_r;
  assign reg_load        = load_r;

endmodule

/* File: tb/rss_top_props.sv */
`timescale 1ns/1ps
// -----------------------------
// Sequencer port checker
// -----------------------------
module rss_top_props
  import rss_pkg::*;
(
  // Clock, reset and inputs
  input wire logic         core_clk,
  input wire logic         resetn,
  input wire logic         supply_above_trip,
  input wire logic         brownout_detect_enable,
  input wire logic [1:0]   brownout_level_select,
  input wire logic [1:0]   osc_mode,
  // Outputs under watch
  input wire logic [1:0]   trip_level_sel,
  input wire logic         brownout_reset,
  input wire logic         chip_reset,
  input wire logic         osc_settle_busy,
  input wire logic         pwrup_busy,
  input wire rss_regload_t reg_load
);
  logic [4:0] low_cnt_r;
  logic [4:0] low_cnt_nxt;

  // Run of low supply samples, saturating so a long dip cannot wrap
  always_comb
  begin
    low_cnt_nxt = supply_above_trip ? 5'h0 : low_cnt_r + 5'h1;
    if (!supply_above_trip && low_cnt_r == 5'h1F)
      low_cnt_nxt = low_cnt_r;
  end

  always_ff @(posedge core_clk)
    low_cnt_r <= low_cnt_nxt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_level_taken: assert property (1'h1 |=> trip_level_sel == $past(brownout_level_select))
    else $error("trip level select not taken");
  a_bor_disabled: assert property (
    !brownout_detect_enable && !brownout_reset |=> !brownout_reset)
    else $error("brown-out while disabled");
  a_bor_filter: assert property ($rose(brownout_reset) |-> low_cnt_r >= 5'h14)
    else $error("brown-out before filter time");
  a_bor_holds: assert property (brownout_reset && !supply_above_trip |=> brownout_reset)
    else $error("brown-out dropped with supply low");
  a_bor_kills_timer: assert property (brownout_reset ##1 brownout_reset |-> !pwrup_busy)
    else $error("power-up timer runs in brown-out");
  a_sources_hold: assert property (
    pwrup_busy || osc_settle_busy || brownout_reset |=> chip_reset)
    else $error("chip released while a source is active");
  a_settle_crystal: assert property (osc_settle_busy |-> osc_mode != OSC_RC_MODE)
    else $error("settle count in RC mode");
  a_release_load: assert property ($fell(chip_reset) |-> ##[0:1] reg_load.load)
    else $error("no register load at release");
  a_reset_values: assert property (
    reg_load.load && reg_load.dir_load |-> reg_load.pc_low == PC_LOW_RESET
    && reg_load.port_a_direction == ALL_ONES_RESET && reg_load.option_value == ALL_ONES_RESET)
    else $error("bad reset register values");
  a_period_ones: assert property (
    reg_load.load |-> reg_load.timer_period_register == ALL_ONES_RESET)
    else $error("period register not all ones");
endmodule

bind rss_top rss_top_props u_props (.core_clk, .resetn, .supply_above_trip, .brownout_detect_enable,
  .brownout_level_select, .osc_mode, .trip_level_sel, .brownout_reset, .chip_reset,
  .osc_settle_busy, .pwrup_busy, .reg_load);

/* File: tb/rss_supply_model.sv */
`timescale 1ns/1ps
// Supply comparator and crystal seen from the sequencer
module rss_supply_model (
  // Command and pins
  input  wire logic dip,
  output logic      supply_above_trip,
  output logic      osc_input_pin
);
  // Free-running crystal, below a quarter of the core clock, phase unrelated
  initial osc_input_pin = 1'h0;
  always #20.3 osc_input_pin = ~osc_input_pin;
  // Comparator follows the commanded supply level
  assign supply_above_trip = !dip;
endmodule

/* File: tb/rss_top_tb.sv */
`timescale 1ns/1ps
module rss_top_tb;
  import rss_pkg::*;
  logic         core_clk               = 1'h0;
  logic         resetn                 = 1'h0;
  logic         dip                    = 1'h0;
  logic         master_clear_pin_n     = 1'h1;
  logic         power_on_pulse         = 1'h1;
  logic         watchdog_timeout       = 1'h0;
  logic         wake_event             = 1'h0;
  logic         wake_by_irq            = 1'h1;
  logic         global_irq_enable      = 1'h0;
  logic [1:0]   brownout_level_select  = 2'h0;
  logic         brownout_detect_enable = 1'h1;
  logic         powerup_timer_enable_n = 1'h0;
  logic [1:0]   osc_mode               = OSC_STANDARD_CRYSTAL;
  logic         supply_above_trip;
  logic         osc_input_pin;
  logic [1:0]   trip_level_sel;
  logic         brownout_reset;
  logic         chip_reset;
  logic         osc_settle_busy;
  logic         pwrup_busy;
  rss_cause_t   reset_cause;
  rss_regload_t reg_load;
  rss_regload_t ld_q;
  int           ld_cnt                 = 0;
  int           osc_rises              = 0;
  int           errors                 = 0;
  int           checks_done            = 0;
  int           n;

  // -----------------------------
  // Clock, partner and design
  // -----------------------------
  always #2.5 core_clk = ~core_clk;

  rss_supply_model u_supply (.dip, .supply_above_trip, .osc_input_pin);

  rss_top DUT (.core_clk, .resetn, .supply_above_trip, .osc_input_pin, .master_clear_pin_n,
    .power_on_pulse, .watchdog_timeout, .wake_event, .wake_by_irq, .global_irq_enable,
    .brownout_level_select, .brownout_detect_enable, .powerup_timer_enable_n, .osc_mode,
    .trip_level_sel, .brownout_reset, .chip_reset, .osc_settle_busy, .pwrup_busy,
    .reset_cause, .reg_load);

  // Capture each load pulse, it stands one cycle only
  always @(posedge core_clk)
    if (reg_load.load === 1'h1)
    begin
      ld_q <= reg_load;
      ld_cnt++;
    end

  // Crystal edges seen while the settle count runs
  always @(posedge osc_input_pin)
    if (osc_settle_busy === 1'h1)
      osc_rises++;

  // -----------------------------
  // Tasks
  // -----------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Length of the next power-up hold, bounded so a stuck timer cannot hang
  task automatic pwr_span(output int k);
    k = 0;
    while (pwrup_busy !== 1'h1 && k < 100)
    begin
      cyc(1);
      k++;
    end
    k = 0;
    while (pwrup_busy === 1'h1 && k < 20000)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic wait_release();
    int k;
    k = 0;
    while (chip_reset !== 1'h0 && k < 12000)
    begin
      cyc(1);
      k++;
    end
    check("release", k < 12000, 1);
    cyc(2);
  endtask

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, about twice the expected run
  initial
  begin
    #500us;
    errors++;
    end_of_test();
  end

  // -----------------------------
  // Tests
  // -----------------------------
  initial
  begin
    cyc(5);
    resetn = 1'h1;
    cyc(3);
    power_on_pulse = 1'h0;
    pwr_span(n);
    check("por delay", n >= 14200 && n <= 14410, 1);
    wait_release();
    check("settle rises", osc_rises >= 1022 && osc_rises <= 1026, 1);
    check("por cause", reset_cause, RSS_CAUSE_POR);
    check("por loads", ld_cnt, 1);
    check("por status", ld_q.status & STATUS_POR_MASK, STATUS_POR_VALUE);
    check("por status load", ld_q.status_load, 1'h1);
    check("por port b", ld_q.port_b_direction, ALL_ONES_RESET);
    // Clear pin then watchdog, crystal mode but no settle count
    for (int k = 0; k < 2; k++)
    begin
      osc_rises = 0;
      ld_cnt = 0;
      master_clear_pin_n = (k != 0);
      watchdog_timeout = (k == 1);
      cyc(10);
      check("src reset", chip_reset, 1);
      master_clear_pin_n = 1'h1;
      watchdog_timeout = 1'h0;
      wait_release();
      check("no settle", osc_rises, 0);
      check("src cause", reset_cause, k ? RSS_CAUSE_WDT : RSS_CAUSE_MASTER_CLEAR_PIN);
      check("src load", {ld_cnt[7:0], ld_q.pc_low}, 16'h0100);
      check("src port b", ld_q.port_b_direction, ALL_ONES_RESET);
      check("src status load", ld_q.status_load, 1'h0);
    end
    // Brown-out with timer bit off, RC mode
    osc_mode = OSC_RC_MODE;
    powerup_timer_enable_n = 1'h1;
    dip = 1'h1;
    cyc(10);
    dip = 1'h0;
    cyc(40);
    check("short dip", brownout_reset, 0);
    dip = 1'h1;
    cyc(60);
    check("bor", {brownout_reset, chip_reset}, 2'h3);
    dip = 1'h0;
    cyc(40);
    check("bor timer", pwrup_busy, 1);
    cyc(5000);
    dip = 1'h1;
    cyc(60);
    check("bor again", {brownout_reset, pwrup_busy}, 2'h2);
    dip = 1'h0;
    pwr_span(n);
    check("bor delay", n >= 14200 && n <= 14410, 1);
    wait_release();
    check("bor cause", reset_cause, RSS_CAUSE_BOR);
    // Detection off ignores a long dip
    brownout_detect_enable = 1'h0;
    dip = 1'h1;
    cyc(60);
    check("bor off", {brownout_reset, chip_reset}, 2'h0);
    dip = 1'h0;
    cyc(5);
    brownout_detect_enable = 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      brownout_level_select = k[1:0];
      cyc(2);
      check("trip level", trip_level_sel, k[1:0]);
    end
    // Wake by interrupt, with and without global enable
    for (int k = 0; k < 2; k++)
    begin
      ld_cnt = 0;
      global_irq_enable = (k == 1);
      wake_event = 1'h1;
      cyc(1);
      wake_event = 1'h0;
      cyc(20);
      check("wake load", {ld_cnt[3:0], ld_q.keep_pc, ld_q.dir_load}, {4'h1, k == 0, 1'h0});
      check("wake period", ld_q.timer_period_register, ALL_ONES_RESET);
      if (k == 1)
        check("wake vector", ld_q.pc_low, IRQ_VECTOR_LOW);
    end
    end_of_test();
  end
endmodule
